// ---- include/mem_decode_pkg.sv ----
// Constants, types and register map of the data memory decoder
package mem_decode_pkg;
   // Software register offsets
   localparam logic [3:0] REG_PAGE = 4'h0;
   localparam logic [3:0] REG_CFG = 4'h1;
   localparam logic [3:0] REG_PSW = 4'h2;
   localparam logic [3:0] REG_SP = 4'h3;
   localparam logic [3:0] REG_DPL = 4'h4;
   localparam logic [3:0] REG_DPH = 4'h5;
   localparam logic [3:0] REG_FLASH = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   // Values after reset
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h03;
   localparam logic [7:0] SP_RST = 8'h07;
   localparam logic [7:0] PSW_RST = 8'h00;
   // Field positions
   localparam int BANK_LSB = 3;
   localparam int MUX_BIT = 4;
   localparam int MODE_LSB = 2;
   localparam logic [3:0] BIT_AREA_HI = 4'h2;
   // Memory modes
   localparam logic [1:0] MODE_ONCHIP = 2'h0;
   localparam logic [1:0] MODE_SPLIT = 2'h1;
   localparam logic [1:0] MODE_OFFCHIP = 2'h3;
   // Security lock byte per flash size
   localparam logic [15:0] LOCK_16K = 16'h3fff;
   localparam logic [15:0] LOCK_15K = 16'h3bff;
   localparam logic [15:0] LOCK_8K = 16'h1fff;
   // Off-chip strobe timing
   localparam int CLK_NS = 100;
   localparam int STROBE_NS = 400;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [3:0] {
      OP_DIRECT, OP_INDIRECT, OP_REG, OP_BIT, OP_PUSH, OP_POP,
      OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, OP_EXTERNAL_MOVE_INSN_RI, OP_CODE
   } op_t;

   typedef struct packed {
      op_t op;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic ri_sel;
      logic [2:0] reg_n;
   } req_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] ad;
      logic ad_oe;
      logic ale;
      logic rd_b;
      logic wr_b;
   } pins_t;
endpackage : mem_decode_pkg

// ---- rtl/mem_decode.sv ----
// Data memory decoder: internal RAM, banks, bits, stack, external data RAM and port
`timescale 1ns/1ns
module mem_decode #(
   parameter int FLASH_KB = 16,
   parameter int STROBE_CYC = mem_decode_pkg::STROBE_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Core access port
   input wire logic req_valid_i,
   input wire mem_decode_pkg::req_t req_i,
   output logic done_o,
   output logic [7:0] rdata_o,
   // Special register space
   output logic sfr_en_o,
   output logic sfr_we_o,
   output logic sfr_bit_o,
   output logic [7:0] sfr_addr_o,
   output logic [7:0] sfr_wdata_o,
   // Flash store
   output logic flash_rd_o,
   output logic flash_wr_o,
   output logic [15:0] flash_addr_o,
   output logic [7:0] flash_wdata_o,
   output logic [15:0] lock_addr_o,
   // Software register port
   input wire logic [3:0] sw_addr_i,
   input wire logic [7:0] sw_wdata_i,
   input wire logic sw_wr_i,
   input wire logic sw_rd_i,
   output logic [7:0] sw_rdata_o,
   // Port latches and pins
   input wire logic [7:0] latch_hi_i,
   input wire logic [7:0] latch_lo_i,
   input wire logic [7:0] latch_ad_i,
   input wire logic [7:0] out_type_i,
   input wire logic [7:0] ad_i,
   output mem_decode_pkg::pins_t pins_o,
   output logic [7:0] out_type_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STRB} st_t;

   if (STROBE_CYC < 3 || STROBE_CYC > 255) begin : g_chk_strb
      $error("STROBE_CYC must lie in 3..255");
   end
   if (FLASH_KB != 16 && FLASH_KB != 15 && FLASH_KB != 8) begin : g_chk_kb
      $error("FLASH_KB must be 16, 15 or 8");
   end

   logic [7:0] iram [0:255];
   logic [7:0] ext_data_ram [0:255];
   logic [7:0] page_reg, cfg_reg, psw_reg, sp_reg, dpl_reg, dph_reg;
   logic flash_wen_reg;
   st_t st_reg;
   logic [7:0] cnt_reg;
   logic [15:0] off_addr_reg;
   logic off_we_reg;
   logic [7:0] off_wdata_reg;
   logic [7:0] ad_s1_reg, ad_s2_reg;

   // Decode of the current request
   logic acc, use_iram, bit_op, to_sfr, is_external_move_insn, start_off, to_ext_data_ram, to_flash;
   logic sp_push, sp_pop, off_end;
   logic [1:0] bank, mode;
   logic [7:0] ia, ptr, ib;
   logic [15:0] eff, off_addr;

   always_comb begin
      acc = req_valid_i && st_reg == ST_IDLE;
      bank = psw_reg[mem_decode_pkg::BANK_LSB +: 2];
      mode = cfg_reg[mem_decode_pkg::MODE_LSB +: 2];
      ptr = iram[{3'b000, bank, 2'b00, req_i.ri_sel}];
      use_iram = 1'b0;
      bit_op = 1'b0;
      to_sfr = 1'b0;
      ia = 8'h00;
      sp_push = 1'b0;
      sp_pop = 1'b0;
      case (req_i.op)
         mem_decode_pkg::OP_REG: begin
            use_iram = 1'b1;
            ia = {3'b000, bank, req_i.reg_n};
         end
         mem_decode_pkg::OP_DIRECT: begin
            to_sfr = req_i.addr[7];
            use_iram = !req_i.addr[7];
            ia = req_i.addr;
         end
         mem_decode_pkg::OP_INDIRECT: begin
            use_iram = 1'b1;
            ia = ptr;
         end
         mem_decode_pkg::OP_BIT: begin
            to_sfr = req_i.addr[7];
            use_iram = !req_i.addr[7];
            bit_op = 1'b1;
            ia = {mem_decode_pkg::BIT_AREA_HI, req_i.addr[6:3]};
         end
         mem_decode_pkg::OP_PUSH: begin
            use_iram = 1'b1;
            sp_push = 1'b1;
            ia = sp_reg + 8'h01;
         end
         mem_decode_pkg::OP_POP: begin
            use_iram = 1'b1;
            sp_pop = 1'b1;
            ia = sp_reg;
         end
         default: begin
            use_iram = 1'b0;
         end
      endcase
      ib = iram[ia];
      is_external_move_insn = req_i.op == mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER ||
                req_i.op == mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_RI;
      // Wide form uses the data pointer, narrow form page plus index
      eff = (req_i.op == mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER) ?
            {dph_reg, dpl_reg} : {page_reg, ptr};
      to_flash = is_external_move_insn && req_i.we && flash_wen_reg;
      start_off = acc && is_external_move_insn && !to_flash && (mode == mem_decode_pkg::MODE_OFFCHIP ||
                  (mode != mem_decode_pkg::MODE_ONCHIP && eff[15:8] != 8'h00));
      to_ext_data_ram = is_external_move_insn && !to_flash && !start_off;
      // Split without bank select: high byte from the port latches
      off_addr = eff;
      if (mode == mem_decode_pkg::MODE_SPLIT &&
          req_i.op == mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_RI) begin
         off_addr[15:8] = latch_hi_i;
      end
      off_end = st_reg == ST_STRB && cnt_reg == 8'h00;
      sp_push = sp_push && acc;
      sp_pop = sp_pop && acc;
   end

   // Software registers; block updates of the stack pointer win
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         page_reg <= mem_decode_pkg::PAGE_RST;
         cfg_reg <= mem_decode_pkg::CFG_RST;
         psw_reg <= mem_decode_pkg::PSW_RST;
         sp_reg <= mem_decode_pkg::SP_RST;
         dpl_reg <= 8'h00;
         dph_reg <= 8'h00;
         flash_wen_reg <= 1'b0;
      end else begin
         if (sw_wr_i) begin
            case (sw_addr_i)
               mem_decode_pkg::REG_PAGE: page_reg <= sw_wdata_i;
               mem_decode_pkg::REG_CFG: cfg_reg <= {3'b000, sw_wdata_i[4:0]};
               mem_decode_pkg::REG_PSW: psw_reg <= sw_wdata_i;
               mem_decode_pkg::REG_SP: sp_reg <= sw_wdata_i;
               mem_decode_pkg::REG_DPL: dpl_reg <= sw_wdata_i;
               mem_decode_pkg::REG_DPH: dph_reg <= sw_wdata_i;
               mem_decode_pkg::REG_FLASH: flash_wen_reg <= sw_wdata_i[0];
               default: ;
            endcase
         end
         if (sp_push) begin
            sp_reg <= sp_reg + 8'h01;
         end else if (sp_pop) begin
            sp_reg <= sp_reg - 8'h01;
         end
      end
   end

   // Software read data, one cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sw_rdata_o <= 8'h00;
      end else if (sw_rd_i) begin
         case (sw_addr_i)
            mem_decode_pkg::REG_PAGE: sw_rdata_o <= page_reg;
            mem_decode_pkg::REG_CFG: sw_rdata_o <= cfg_reg;
            mem_decode_pkg::REG_PSW: sw_rdata_o <= psw_reg;
            mem_decode_pkg::REG_SP: sw_rdata_o <= sp_reg;
            mem_decode_pkg::REG_DPL: sw_rdata_o <= dpl_reg;
            mem_decode_pkg::REG_DPH: sw_rdata_o <= dph_reg;
            mem_decode_pkg::REG_FLASH: sw_rdata_o <= {7'h00, flash_wen_reg};
            mem_decode_pkg::REG_STATUS: sw_rdata_o <= {6'h00, pins_o.ale, st_reg != ST_IDLE};
            default: sw_rdata_o <= 8'h00;
         endcase
      end else begin
         sw_rdata_o <= 8'h00;
      end
   end

   // On-chip storage writes; arrays carry no reset
   always_ff @(posedge mclk_i) begin
      if (acc && req_i.we && use_iram) begin
         if (bit_op) begin
            iram[ia][req_i.addr[2:0]] <= req_i.wdata[0];
         end else begin
            iram[ia] <= req_i.wdata;
         end
      end
      if (acc && req_i.we && to_ext_data_ram) begin
         ext_data_ram[eff[7:0]] <= req_i.wdata;
      end
   end

   // Answers to the core, special register and flash strobes
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         done_o <= 1'b0;
         rdata_o <= 8'h00;
         sfr_en_o <= 1'b0;
         sfr_we_o <= 1'b0;
         sfr_bit_o <= 1'b0;
         sfr_addr_o <= 8'h00;
         sfr_wdata_o <= 8'h00;
         flash_rd_o <= 1'b0;
         flash_wr_o <= 1'b0;
         flash_addr_o <= 16'h0000;
         flash_wdata_o <= 8'h00;
      end else begin
         done_o <= (acc && !start_off) || off_end;
         sfr_en_o <= acc && to_sfr;
         sfr_we_o <= acc && to_sfr && req_i.we;
         sfr_bit_o <= acc && to_sfr && bit_op;
         sfr_addr_o <= req_i.addr;
         sfr_wdata_o <= req_i.wdata;
         flash_rd_o <= acc && req_i.op == mem_decode_pkg::OP_CODE;
         flash_wr_o <= acc && to_flash;
         flash_wdata_o <= req_i.wdata;
         if (req_i.op == mem_decode_pkg::OP_CODE) begin
            flash_addr_o <= {dph_reg, dpl_reg} + {8'h00, req_i.addr};
         end else begin
            flash_addr_o <= eff;
         end
         if (off_end) begin
            rdata_o <= ad_s2_reg;
         end else if (acc && use_iram && bit_op) begin
            rdata_o <= {7'h00, ib[req_i.addr[2:0]]};
         end else if (acc && use_iram) begin
            rdata_o <= ib;
         end else if (acc && to_ext_data_ram) begin
            rdata_o <= ext_data_ram[eff[7:0]];
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   // Input pins pass two flops before use
   always_ff @(posedge mclk_i) begin
      ad_s1_reg <= ad_i;
      ad_s2_reg <= ad_s1_reg;
   end

   // Off-chip sequence; address captured at start so it runs atomically
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         st_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         off_addr_reg <= 16'h0000;
         off_we_reg <= 1'b0;
         off_wdata_reg <= 8'h00;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               if (start_off) begin
                  st_reg <= ST_ADDR;
                  off_addr_reg <= off_addr;
                  off_we_reg <= req_i.we;
                  off_wdata_reg <= req_i.wdata;
               end
            end
            ST_ADDR: begin
               st_reg <= ST_STRB;
               cnt_reg <= 8'(STROBE_CYC - 1);
            end
            ST_STRB: begin
               if (cnt_reg == 8'h00) begin
                  st_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Pin drive; latches own the pins outside a transfer
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         pins_o <= '{8'hff, 8'hff, 8'hff, 1'b1, 1'b0, 1'b1, 1'b1};
         out_type_o <= 8'h00;
      end else begin
         out_type_o <= out_type_i;
         if ((st_reg == ST_IDLE && !start_off) || off_end) begin
            pins_o <= '{latch_hi_i, latch_lo_i, latch_ad_i, 1'b1, 1'b0, 1'b1, 1'b1};
         end else if (st_reg == ST_IDLE) begin
            // Address phase: multiplexed drives low byte on data lines
            pins_o.hi <= off_addr[15:8];
            pins_o.lo <= off_addr[7:0];
            pins_o.ad <= cfg_reg[mem_decode_pkg::MUX_BIT] ? req_i.wdata : off_addr[7:0];
            pins_o.ad_oe <= !cfg_reg[mem_decode_pkg::MUX_BIT] || req_i.we;
            pins_o.ale <= !cfg_reg[mem_decode_pkg::MUX_BIT];
         end else if (st_reg == ST_ADDR) begin
            pins_o.ale <= 1'b0;
            pins_o.ad <= off_wdata_reg;
            pins_o.ad_oe <= off_we_reg;
            pins_o.rd_b <= off_we_reg;
            pins_o.wr_b <= !off_we_reg;
         end
      end
   end

   // Lock byte address follows the flash size
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         lock_addr_o <= 16'h0000;
      end else begin
         lock_addr_o <= (FLASH_KB == 16) ? mem_decode_pkg::LOCK_16K :
                        (FLASH_KB == 15) ? mem_decode_pkg::LOCK_15K :
                        mem_decode_pkg::LOCK_8K;
      end
   end

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   sp_reset_a: assert property ($past(rst_b_i) == 1'b0 |-> sp_reg == 8'h07)
      else $error("stack pointer not 0x07 after reset");
   push_inc_a: assert property (sp_push |=> sp_reg == 8'($past(sp_reg) + 8'h01))
      else $error("push did not advance stack pointer");
   push_store_a: assert property (sp_push && req_i.we |=> iram[sp_reg] == $past(req_i.wdata))
      else $error("push data not at new stack top");
   bank_read_a: assert property (acc && req_i.op == mem_decode_pkg::OP_REG && !req_i.we
      |=> rdata_o == iram[{3'b000, $past(bank), $past(req_i.reg_n)}])
      else $error("working register read from wrong address");
   sfr_route_a: assert property (acc && req_i.op == mem_decode_pkg::OP_DIRECT && req_i.addr[7]
      |=> sfr_en_o && sfr_addr_o == $past(req_i.addr))
      else $error("direct high access missed special registers");
   alias_onchip_a: assert property (acc && is_external_move_insn && mode == mem_decode_pkg::MODE_ONCHIP
      |-> !start_off)
      else $error("on-chip only mode went off-chip");
   pin_release_a: assert property (start_off |-> ##[4:40] (done_o && pins_o.rd_b
      && pins_o.wr_b && !pins_o.ale))
      else $error("off-chip move did not release pins");
   read_drv_a: assert property (st_reg == ST_STRB && !off_we_reg |-> !pins_o.ad_oe)
      else $error("data drivers on during read");
   flash_wr_a: assert property (acc && is_external_move_insn && req_i.we && flash_wen_reg
      |=> flash_wr_o && !done_o == 1'b0)
      else $error("flash write not issued");
   cv_push: cover property (sp_push ##1 sp_pop);
   cv_off_rd: cover property (start_off && !req_i.we ##[4:40] done_o);
   cv_bit_wr: cover property (acc && bit_op && req_i.we && use_iram);
endmodule : mem_decode

// ---- test/ext_mem_model.sv ----
// Off-chip memory model on the multiplexed port pins
`timescale 1ns/1ns
module ext_mem_model (
   // Clock
   input wire logic mclk_i,
   // Pins from the decoder
   input wire mem_decode_pkg::pins_t pins_i,
   // Data lines back
   output logic [7:0] ad_o
);
   logic [7:0] mem [0:255];
   logic [7:0] addr_reg;
   logic [7:0] last_reg;
   // Preload with the inverse of the low address
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = ~i[7:0];
      end
      addr_reg = 8'h00;
      last_reg = 8'h00;
   end
   // Low address taken on ale; high byte ignored, so pages alias here
   always @(posedge mclk_i) begin
      if (pins_i.ale) begin
         addr_reg <= pins_i.ad;
      end
      if (!pins_i.wr_b) begin
         mem[addr_reg] <= pins_i.ad;
      end
      last_reg <= ad_o;
   end
   // Outside a read strobe the lines toggle, so stale data never matches
   assign ad_o = !pins_i.rd_b ? mem[addr_reg] : ~last_reg;
endmodule : ext_mem_model

// ---- test/test_mem_decode.sv ----
// Self-checking bench for the data memory decoder
`timescale 1ns/1ns
module test_mem_decode;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic req_valid_i = 1'b0;
   mem_decode_pkg::req_t req_i = '0;
   logic done_o, sfr_en_o, sfr_we_o, sfr_bit_o, flash_rd_o, flash_wr_o;
   logic [7:0] rdata_o, sfr_addr_o, sfr_wdata_o, flash_wdata_o, sw_rdata_o, out_type_o;
   logic [15:0] flash_addr_o, lock_addr_o, fl_addr;
   logic [3:0] sw_addr_i = 4'h0;
   logic [7:0] sw_wdata_i = 8'h00;
   logic sw_wr_i = 1'b0;
   logic sw_rd_i = 1'b0;
   logic [7:0] latch_i = 8'hff;
   logic [7:0] out_type_i = 8'h3c;
   logic [7:0] ad_i, mem_ad, q;
   mem_decode_pkg::pins_t pins_o;
   logic seen_sfr, seen_stb, oe_stb, fl_rd, fl_wr;
   logic [15:0] adr_seen;
   logic [10:0] sfr_cap;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   always #50 mclk_i = ~mclk_i;
   // Wire level: the decoder wins while it drives, else the model
   assign ad_i = pins_o.ad_oe ? pins_o.ad : mem_ad;
   mem_decode #(.FLASH_KB(16), .STROBE_CYC(3)) i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .done_o(done_o), .rdata_o(rdata_o),
      .sfr_en_o(sfr_en_o), .sfr_we_o(sfr_we_o), .sfr_bit_o(sfr_bit_o),
      .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o), .flash_rd_o(flash_rd_o),
      .flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
      .lock_addr_o(lock_addr_o), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
      .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .latch_hi_i(latch_i),
      .latch_lo_i(latch_i), .latch_ad_i(latch_i), .out_type_i(out_type_i), .ad_i(ad_i),
      .pins_o(pins_o), .out_type_o(out_type_o));
   ext_mem_model i_mem (.mclk_i(mclk_i), .pins_i(pins_o), .ad_o(mem_ad));

   task automatic summarize();
      $display("Checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      sw_wr_i <= 1'b1;
      sw_addr_i <= a;
      sw_wdata_i <= d;
      @(posedge mclk_i);
      sw_wr_i <= 1'b0;
   endtask : sw_wr

   task automatic sw_rd(input logic [3:0] a, input logic [7:0] e, input string what);
      @(posedge mclk_i);
      sw_rd_i <= 1'b1;
      sw_addr_i <= a;
      @(posedge mclk_i);
      sw_rd_i <= 1'b0;
      @(negedge mclk_i);
      chk(what, e, sw_rdata_o);
   endtask : sw_rd

   // One core request; waits for done under a bound and keeps side outputs
   task automatic core(input mem_decode_pkg::op_t op, input logic we, input logic [7:0] a,
         input logic [7:0] d, input logic [2:0] n);
      int k;
      @(posedge mclk_i);
      req_valid_i <= 1'b1;
      req_i <= '{op: op, we: we, addr: a, wdata: d, ri_sel: n[0], reg_n: n};
      @(posedge mclk_i);
      req_valid_i <= 1'b0;
      seen_stb = 1'b0;
      adr_seen = 16'h0000;
      for (k = 0; k < 20; k++) begin
         @(negedge mclk_i);
         // Address as it stands on the pins while the latch strobe is up
         if (pins_o.ale === 1'b1) begin
            adr_seen = {pins_o.hi, pins_o.ad};
         end
         if (pins_o.rd_b === 1'b0 || pins_o.wr_b === 1'b0) begin
            seen_stb = 1'b1;
            oe_stb = pins_o.ad_oe;
         end
         if (done_o === 1'b1) break;
         @(posedge mclk_i);
      end
      chk("done", 16'h0001, done_o);
      seen_sfr = sfr_en_o;
      sfr_cap = {sfr_en_o, sfr_we_o, sfr_bit_o, sfr_addr_o};
      fl_rd = flash_rd_o;
      fl_wr = flash_wr_o;
      fl_addr = flash_addr_o;
      q = rdata_o;
   endtask : core

   // Cycle ceiling well above the expected few hundred cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      repeat (8) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      sw_rd(mem_decode_pkg::REG_SP, 8'h07, "sp reset");
      sw_rd(mem_decode_pkg::REG_PAGE, 8'h00, "page reset");
      sw_rd(mem_decode_pkg::REG_CFG, 8'h03, "cfg reset");
      sw_rd(4'h8, 8'h00, "unmapped");
      chk("lock", 16'h3fff, lock_addr_o);
      chk("out type", out_type_i, out_type_o);
      // Each bank, register 5, read back directly at 8*bank+5
      for (int b = 0; b < 4; b++) begin
         sw_wr(mem_decode_pkg::REG_PSW, {3'h0, b[1:0], 3'h0});
         core(mem_decode_pkg::OP_REG, 1'b1, 8'h00, 8'h40 + b[7:0], 3'h5);
         core(mem_decode_pkg::OP_DIRECT, 1'b0, {b[4:0], 3'h5}, 8'h00, 3'h0);
         chk("bank reg", 8'h40 + b[7:0], q);
         core(mem_decode_pkg::OP_REG, 1'b0, 8'h00, 8'h00, 3'h5);
         chk("reg read", 8'h40 + b[7:0], q);
      end
      // Upper RAM by pointer, special space by direct address
      core(mem_decode_pkg::OP_REG, 1'b1, 8'h00, 8'h90, 3'h0);
      core(mem_decode_pkg::OP_INDIRECT, 1'b1, 8'h00, 8'ha5, 3'h0);
      core(mem_decode_pkg::OP_INDIRECT, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("upper ram", 8'ha5, q);
      chk("no sfr", 16'h0000, seen_sfr);
      core(mem_decode_pkg::OP_DIRECT, 1'b0, 8'h90, 8'h00, 3'h0);
      chk("sfr", 16'h0001, seen_sfr);
      core(mem_decode_pkg::OP_BIT, 1'b1, 8'h85, 8'h01, 3'h0);
      chk("sfr bit", 16'h0785, sfr_cap);
      core(mem_decode_pkg::OP_REG, 1'b1, 8'h00, 8'h30, 3'h1);
      core(mem_decode_pkg::OP_INDIRECT, 1'b1, 8'h00, 8'h3c, 3'h1);
      core(mem_decode_pkg::OP_DIRECT, 1'b0, 8'h30, 8'h00, 3'h0);
      chk("lower ram", 8'h3c, q);
      // Bit 0x13 is bit 3 of byte 0x22
      core(mem_decode_pkg::OP_DIRECT, 1'b1, 8'h22, 8'h00, 3'h0);
      core(mem_decode_pkg::OP_BIT, 1'b1, 8'h13, 8'h01, 3'h0);
      core(mem_decode_pkg::OP_DIRECT, 1'b0, 8'h22, 8'h00, 3'h0);
      chk("bit byte", 8'h08, q);
      core(mem_decode_pkg::OP_BIT, 1'b0, 8'h13, 8'h00, 3'h0);
      chk("bit set", 8'h01, q);
      core(mem_decode_pkg::OP_BIT, 1'b0, 8'h12, 8'h00, 3'h0);
      chk("bit clear", 8'h00, q);
      // First push lands at 0x08; then wrap from 0xff to 0x00
      core(mem_decode_pkg::OP_PUSH, 1'b1, 8'h00, 8'h77, 3'h0);
      sw_rd(mem_decode_pkg::REG_SP, 8'h08, "sp push");
      core(mem_decode_pkg::OP_DIRECT, 1'b0, 8'h08, 8'h00, 3'h0);
      chk("push slot", 8'h77, q);
      sw_wr(mem_decode_pkg::REG_SP, 8'hff);
      core(mem_decode_pkg::OP_PUSH, 1'b1, 8'h00, 8'h66, 3'h0);
      sw_rd(mem_decode_pkg::REG_SP, 8'h00, "sp wrap");
      core(mem_decode_pkg::OP_POP, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("pop", 8'h66, q);
      sw_rd(mem_decode_pkg::REG_SP, 8'hff, "sp pop");
      // Pointer bytes, then config in the software order
      sw_wr(mem_decode_pkg::REG_DPH, 8'h12);
      sw_wr(mem_decode_pkg::REG_DPL, 8'h34);
      sw_rd(mem_decode_pkg::REG_DPH, 8'h12, "dph");
      sw_rd(mem_decode_pkg::REG_DPL, 8'h34, "dpl");
      sw_wr(mem_decode_pkg::REG_CFG, 8'hff);
      sw_rd(mem_decode_pkg::REG_CFG, 8'h1f, "cfg unused");
      sw_wr(mem_decode_pkg::REG_CFG, 8'h00);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b1, 8'h00, 8'hc3, 3'h0);
      sw_wr(mem_decode_pkg::REG_PAGE, 8'h12);
      core(mem_decode_pkg::OP_REG, 1'b1, 8'h00, 8'h34, 3'h0);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_RI, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("ext_data_ram", 8'hc3, q);
      sw_wr(mem_decode_pkg::REG_PAGE, 8'h56);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_RI, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("alias", 8'hc3, q);
      chk("no pins", 16'h0000, seen_stb);
      // Code read uses pointer plus offset, always from flash
      core(mem_decode_pkg::OP_CODE, 1'b0, 8'h01, 8'h00, 3'h0);
      chk("code rd", 16'h0001, fl_rd);
      chk("code addr", 16'h1235, fl_addr);
      sw_wr(mem_decode_pkg::REG_FLASH, 8'h01);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b1, 8'h00, 8'h99, 3'h0);
      chk("flash wr", 16'h0001, fl_wr);
      chk("flash data", 8'h99, flash_wdata_o);
      sw_wr(mem_decode_pkg::REG_FLASH, 8'h00);
      // Off-chip only, multiplexed pins
      sw_wr(mem_decode_pkg::REG_CFG, 8'h0c);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("ext rd", 8'hcb, q);
      chk("ext addr", 16'h1234, adr_seen);
      chk("rd strobe", 16'h0001, seen_stb);
      chk("rd oe", 16'h0000, oe_stb);
      chk("pins back", latch_i, pins_o.ad);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b1, 8'h00, 8'h5a, 3'h0);
      chk("wr oe", 16'h0001, oe_stb);
      chk("pins hi", latch_i, pins_o.hi);
      // Split: from 256 up off-chip, below on-chip
      sw_wr(mem_decode_pkg::REG_CFG, 8'h04);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("split ext", 8'h5a, q);
      sw_wr(mem_decode_pkg::REG_DPH, 8'h00);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("split int", 8'hc3, q);
      chk("split pins", 16'h0000, seen_stb);
      // Narrow form off-chip: high byte from latches, then from page
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_RI, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("latch hi", 16'hff34, adr_seen);
      chk("split ri", 8'h5a, q);
      sw_wr(mem_decode_pkg::REG_CFG, 8'h08);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_RI, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("page hi", 16'h5634, adr_seen);
      chk("bank ext", 8'h5a, q);
      // Separate pins: no latch strobe, data lines undriven on read
      sw_wr(mem_decode_pkg::REG_CFG, 8'h1c);
      core(mem_decode_pkg::OP_EXTERNAL_MOVE_INSN_WIDE_DATA_POINTER, 1'b0, 8'h00, 8'h00, 3'h0);
      chk("sep ale", 16'h0000, adr_seen);
      chk("sep oe", 16'h0000, oe_stb);
      summarize();
   end
endmodule : test_mem_decode
